// ==== cld_lock_detect_control.v ====
// Frequency acquisition, loss-of-lock detection, sticky status and
// loss-of-signal indication of a continuous rate clock recovery receiver.
// Assumes the host control bits come from logic on ref_clk; oscillator,
// data and reference clocks arrive as asynchronous pins.
//
// How it works
// - Acquire lock at any rate in the span, no reference clock needed.
// - Error above 1000 ppm raises loss-of-lock and starts acquisition.
// - Each normal acquisition first sets the tuning word to its bottom.
// - Coarse steps then halving steps; lock declared within 250 ppm.
// - After lock the frequency loop is turned off for the phase loop.
// - Level below threshold drives signal-absent high by default.
// - Polarity bit set to one makes signal-absent active low.
// - Signal-absent clears only when level reaches twice the threshold.
// - Reference mode compares oscillator with scaled reference, 250 ppm.
// - Reference mode loss above 1000 ppm reacquires against reference.
// - Sticky status bit four sets on every loss, stays after relock.
// - Writing one then zero to clear bit clears the sticky bit.
// - Output select one mirrors sticky bit on the pin, else live state.
// - Lower harmonic input forces loss-of-lock and a fresh acquisition.
// - Higher rates are not flagged; ordinary loss handles them.
// - Harmonic check finishes within 16384 bit periods over density.
// - Harmonic detector is off while reference mode is enabled.
// - Range code 00..11 selects 12.3-25 up to 100-200 MHz reference.
// - Target: data rate over two to ratio equals ref over two to range.
`include "cld_defines.vh"

module cld_lock_detect_control #(
	parameter CW         = 16,
	parameter TW         = 12,
	parameter LW         = 8,
	parameter HARM_TICKS = `CLD_HARM_TICKS
) (
	input  wire          ref_clk,
	input  wire          resetn,
	input  wire          vco_clock_in,
	input  wire          data_in,
	input  wire          aux_ref_clock_in,
	input  wire [LW-1:0] signal_level,
	input  wire [LW-1:0] los_threshold,
	input  wire          ref_lock_mode,
	input  wire          fine_readback_enable,
	input  wire [1:0]    ref_range,
	input  wire [3:0]    rate_ratio,
	input  wire          los_polarity,
	input  wire          sticky_clear,
	input  wire          lol_output_select,
	output reg  [TW-1:0] vco_tune_word,
	output reg           freq_loop_enable,
	output wire          lock_lost_out,
	output reg           signal_absent_out,
	output reg  [7:0]    lock_status,
	output reg           harmonic_seen
);
	// One-hot acquisition states.
	localparam [3:0] ST_BOTTOM  = 4'h1;
	localparam [3:0] ST_MEASURE = 4'h2;
	localparam [3:0] ST_STEP    = 4'h4;
	localparam [3:0] ST_LOCKED  = 4'h8;
	localparam [31:0] WIN_LAST  = `CLD_WINDOW_CYCLES - 1;
	localparam [TW-1:0] STEP_COARSE = {2'b01, {(TW-2){1'b0}}};
	localparam [TW-1:0] STEP_FINE   = {{(TW-1){1'b0}}, 1'b1};

	reg  [3:0]    state;
	reg  [3:0]    next_state;
	reg  [31:0]   win_cnt;
	reg           window_done;
	reg           window_seen;
	reg  [TW-1:0] step;
	reg           lol_live;
	reg           clear_armed;
	reg           los_state;
	reg  [31:0]   harm_ticks;
	reg  [1:0]    run_len;
	reg           prev_bit;
	reg           saw_single;
	wire [CW-1:0] vco_cnt;
	wire [CW-1:0] data_cnt;
	wire [CW-1:0] ref_cnt;
	wire          vco_tick;
	wire          data_level;
	wire          ref_mode;
	wire [31:0]   ref_scaled;
	wire [31:0]   target;
	wire [31:0]   vco_ext;
	wire [31:0]   diff;
	wire          within_lock;
	wire          beyond_loss;
	wire          vco_low;
	wire          harm_enable;
	wire          harm_flag;
	wire          lol_event;
	wire          clear_pulse;
	wire [LW:0]   level_ext;
	wire [LW:0]   hyst_level;

	// Oscillator edge counter; also gives the bit-period tick.
	cld_edge_counter #(.CW(CW)) u_vco_count (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.sig_in      (vco_clock_in),
		.window_done (window_done),
		.level       (),
		.edge_pulse  (vco_tick),
		.count       (vco_cnt)
	);

	// Data rate counter; its synced level feeds the harmonic detector.
	cld_edge_counter #(.CW(CW)) u_data_count (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.sig_in      (data_in),
		.window_done (window_done),
		.level       (data_level),
		.edge_pulse  (),
		.count       (data_cnt)
	);

	// Reference clock counter, used only in reference mode.
	cld_edge_counter #(.CW(CW)) u_ref_count (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.sig_in      (aux_ref_clock_in),
		.window_done (window_done),
		.level       (),
		.edge_pulse  (),
		.count       (ref_cnt)
	);

	// Fixed measurement window shared by all counters.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			win_cnt     <= 32'h0000_0000;
			window_done <= 1'b0;
		end else if (win_cnt == WIN_LAST) begin
			win_cnt     <= 32'h0000_0000;
			window_done <= 1'b1;
		end else begin
			win_cnt     <= win_cnt + 32'h0000_0001;
			window_done <= 1'b0;
		end
	end

	// Reference mode wins if the host sets the forbidden pair anyway;
	// that keeps the block deterministic where the device is undefined.
	assign ref_mode = ref_lock_mode;

	// Scale the reference count by two to the ratio, divide by two to the
	// range; range codes 00..11 stand for four octave reference bands.
	assign ref_scaled = ({16'h0000, ref_cnt} << rate_ratio) >> ref_range;

	// Target is data rate in normal mode, scaled reference otherwise.
	assign target = ref_mode ? ref_scaled : {16'h0000, data_cnt};
	assign vco_ext = {16'h0000, vco_cnt};
	assign vco_low = vco_ext < target;
	assign diff    = vco_low ? (target - vco_ext) : (vco_ext - target);

	// The two thresholds; the gap between them is the hysteresis.
	assign within_lock = (diff * `CLD_LOCK_DIV) <= target;
	assign beyond_loss = (diff * `CLD_LOSS_DIV) > target;

	// Window results are used one cycle late, once the counts settled.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			window_seen <= 1'b0;
		end else begin
			window_seen <= window_done;
		end
	end

	// Next state of the acquisition sequencer.
	always @* begin
		next_state = state;
		case (state)
			ST_BOTTOM: begin
				next_state = ST_MEASURE;
			end
			ST_MEASURE: begin
				if (window_seen) begin
					if (within_lock) begin
						next_state = ST_LOCKED;
					end else begin
						next_state = ST_STEP;
					end
				end
			end
			ST_STEP: begin
				next_state = ST_MEASURE;
			end
			ST_LOCKED: begin
				if (window_seen && beyond_loss) begin
					next_state = ST_BOTTOM;
				end else if (harm_flag) begin
					next_state = ST_BOTTOM;
				end
			end
			default: begin
				next_state = ST_BOTTOM;
			end
		endcase
	end

	// Sequencer registers, tuning word and step size.
	// A step that overshoots is undone in full and the step halved, so the word homes in
	// like a binary search and never needs a downward restart.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state         <= ST_BOTTOM;
			vco_tune_word <= `CLD_TUNE_MIN;
			step          <= STEP_COARSE;
		end else begin
			state <= next_state;
			case (state)
				ST_BOTTOM: begin
					vco_tune_word <= `CLD_TUNE_MIN;
					step          <= STEP_COARSE;
				end
				ST_STEP: begin
					if (vco_low) begin
						if (vco_tune_word <= ~step) begin
							vco_tune_word <= vco_tune_word + step;
						end
					end else begin
						if (vco_tune_word >= step) begin
							vco_tune_word <= vco_tune_word - step;
						end
						if (step != STEP_FINE) begin
							step <= step >> 1;
						end
					end
				end
				default: begin
					vco_tune_word <= vco_tune_word;
				end
			endcase
		end
	end

	// Live loss-of-lock and frequency loop enable follow the state.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lol_live         <= 1'b1;
			freq_loop_enable <= 1'b1;
		end else begin
			lol_live         <= (next_state != ST_LOCKED);
			freq_loop_enable <= (next_state != ST_LOCKED);
		end
	end

	// A loss event is the step from locked back into acquisition.
	assign lol_event = (state == ST_LOCKED) && (next_state != ST_LOCKED);

	// Clear is armed by a one and fires on the following zero.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			clear_armed <= 1'b0;
		end else if (sticky_clear) begin
			clear_armed <= 1'b1;
		end else begin
			clear_armed <= 1'b0;
		end
	end

	assign clear_pulse = clear_armed & ~sticky_clear;

	// Sticky status; a loss in the clear cycle still sets the bit.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lock_status <= `CLD_STATUS_RESET;
		end else if (lol_event) begin
			lock_status[`CLD_STICKY_BIT] <= 1'b1;
		end else if (clear_pulse) begin
			lock_status[`CLD_STICKY_BIT] <= 1'b0;
		end
	end

	// Pin shows either the sticky bit or the live acquisition state.
	assign lock_lost_out = lol_output_select ?
		lock_status[`CLD_STICKY_BIT] : lol_live;

	// Loss of signal with a 6 dB band: deassert only at twice threshold.
	assign level_ext  = {1'b0, signal_level};
	assign hyst_level = {los_threshold, 1'b0};

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			los_state <= 1'b0;
		end else if (signal_level < los_threshold) begin
			los_state <= 1'b1;
		end else if (level_ext >= hyst_level) begin
			los_state <= 1'b0;
		end
	end

	// Polarity is applied at the output flop so the pin never glitches.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			signal_absent_out <= 1'b0;
		end else begin
			signal_absent_out <= los_state ^ los_polarity;
		end
	end

	// Harmonic detector runs only while locked in normal mode.
	assign harm_enable = (state == ST_LOCKED) && !ref_mode;

	// A true-rate stream shows isolated single bits; a lower harmonic
	// stretches every run to two bits or more. Higher rates are left to
	// the frequency comparison, which sees them as an ordinary loss.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			harm_ticks <= 32'h0000_0000;
			run_len    <= `CLD_RUN_RESET;
			prev_bit   <= 1'b0;
			saw_single <= 1'b0;
		end else if (!harm_enable || harm_flag) begin
			harm_ticks <= 32'h0000_0000;
			run_len    <= `CLD_RUN_RESET;
			saw_single <= 1'b0;
		end else if (vco_tick) begin
			prev_bit <= data_level;
			if (harm_ticks == HARM_TICKS - 1) begin
				harm_ticks <= 32'h0000_0000;
				saw_single <= 1'b0;
			end else begin
				harm_ticks <= harm_ticks + 32'h0000_0001;
			end
			if (data_level != prev_bit) begin
				if (run_len == `CLD_RUN_SINGLE) begin
					saw_single <= 1'b1;
				end
				run_len <= `CLD_RUN_SINGLE;
			end else if (run_len != `CLD_RUN_RESET) begin
				run_len <= `CLD_RUN_LONG;
			end
		end
	end

	// Flag at the end of a span in which no isolated bit was seen.
	assign harm_flag = harm_enable && vco_tick &&
		(harm_ticks == HARM_TICKS - 1) && !saw_single;

	// Registered copy of the harmonic verdict for observation.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			harmonic_seen <= 1'b0;
		end else begin
			harmonic_seen <= harm_flag;
		end
	end
endmodule // cld_lock_detect_control

// ==== cld_defines.vh ====
// Shared constants for the lock detect and acquisition control block.
// Assumes ref_clk at 40 MHz; included by its bare name from every design file.
`ifndef CLD_DEFINES_VH
`define CLD_DEFINES_VH

// Clock rate of ref_clk in MHz.
`define CLD_CLK_MHZ 40
// Frequency measurement window in ns.
`define CLD_WINDOW_NS 100000
// Window length in ref_clk cycles, derived from the time and the rate.
`define CLD_WINDOW_CYCLES (`CLD_WINDOW_NS * `CLD_CLK_MHZ / 1000)
// Lock threshold 250 ppm is one part in this divisor.
`define CLD_LOCK_DIV 32'd4000
// Loss threshold 1000 ppm is one part in this divisor.
`define CLD_LOSS_DIV 32'd1000
// Harmonic check span in recovered bit periods.
`define CLD_HARM_TICKS 16384
// Bottom of the oscillator tuning range.
`define CLD_TUNE_MIN 12'h000
// Position of the sticky loss-of-lock bit in the status byte.
`define CLD_STICKY_BIT 4
// Reset value of the status byte.
`define CLD_STATUS_RESET 8'h00
// Reset value of a run length tracker.
`define CLD_RUN_RESET 2'h0
// Run length that marks an isolated single bit.
`define CLD_RUN_SINGLE 2'h1
// Saturated run length meaning two bits or more.
`define CLD_RUN_LONG 2'h2

`endif

// ==== cld_edge_counter.v ====
// Edge counter used for every frequency measurement of the block.
// Assumes sig_in is asynchronous to ref_clk and slower than half its rate.
`include "cld_defines.vh"

module cld_edge_counter #(
	parameter CW = 16
) (
	input  wire          ref_clk,
	input  wire          resetn,
	input  wire          sig_in,
	input  wire          window_done,
	output wire          level,
	output wire          edge_pulse,
	output reg  [CW-1:0] count
);
	reg          sync1;
	reg          sync2;
	reg          last;
	reg [CW-1:0] running;

	// Two flops bring the pin into ref_clk; only sync2 is read downstream.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			last  <= 1'b0;
		end else begin
			sync1 <= sig_in;
			sync2 <= sync1;
			last  <= sync2;
		end
	end

	assign level      = sync2;
	assign edge_pulse = sync2 & ~last;

	// Count rising edges and latch the total at each window end.
	// The counter saturates so that a too fast input never wraps to low.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			running <= {CW{1'b0}};
			count   <= {CW{1'b0}};
		end else if (window_done) begin
			count   <= running;
			running <= {{(CW-1){1'b0}}, edge_pulse};
		end else if (edge_pulse && running != {CW{1'b1}}) begin
			running <= running + {{(CW-1){1'b0}}, 1'b1};
		end
	end
endmodule // cld_edge_counter

// ==== cld_lock_detect_control_properties.sv ====
// Concurrent checks for the lock detect block, seen from its top ports.
// Assumes one clock domain on ref_clk with resetn asynchronous, active low.
module cld_lock_detect_control_checker #(
	parameter TW = 12,
	parameter LW = 8
) (
	input wire          ref_clk,
	input wire          resetn,
	input wire [LW-1:0] signal_level,
	input wire [LW-1:0] los_threshold,
	input wire          ref_lock_mode,
	input wire          los_polarity,
	input wire          sticky_clear,
	input wire          lol_output_select,
	input wire [TW-1:0] vco_tune_word,
	input wire          freq_loop_enable,
	input wire          lock_lost_out,
	input wire          signal_absent_out,
	input wire [7:0]    lock_status,
	input wire          harmonic_seen
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Signal-absent follows the level two cycles on, polarity applied.
	chk_los_set: assert property ((signal_level < los_threshold)
		|=> ##1 (signal_absent_out == !$past(los_polarity))) else $error("los set");
	chk_los_clear: assert property (
		({1'b0, signal_level} >= {los_threshold, 1'b0})
		|=> ##1 (signal_absent_out == $past(los_polarity))) else $error("los clear");
	// Inside the hysteresis band only a polarity change may move the pin.
	chk_los_hold: assert property ((signal_level >= los_threshold &&
		{1'b0, signal_level} < {los_threshold, 1'b0}) |=> ##1 (signal_absent_out ==
		($past(signal_absent_out) ^ $past(los_polarity) ^ $past(los_polarity, 2))))
		else $error("los hold");
	// The pin shows either live acquisition state or the sticky bit.
	chk_lol_live: assert property (!lol_output_select |->
		(lock_lost_out == freq_loop_enable)) else $error("lol live");
	chk_lol_mirror: assert property (lol_output_select |->
		(lock_lost_out == lock_status[4])) else $error("lol mirror");
	chk_status_rsvd: assert property ((lock_status & 8'hef) == 8'h00)
		else $error("status spare bits");
	// Every return to acquisition sets the sticky bit; one in normal mode starts at the bottom.
	chk_sticky_set: assert property ($rose(freq_loop_enable)
		|-> ##[0:2] lock_status[4]) else $error("sticky set");
	chk_sticky_clear: assert property ($fell(lock_status[4]) |->
		!$past(sticky_clear) && ($past(sticky_clear, 2) || $past(sticky_clear, 3)))
		else $error("sticky clear");
	chk_bottom_start: assert property ((!ref_lock_mode &&
		$rose(freq_loop_enable)) |-> ##[0:3] (vco_tune_word == '0))
		else $error("tune word bottom");
	chk_word_frozen: assert property ((!freq_loop_enable &&
		!$past(freq_loop_enable)) |-> $stable(vco_tune_word)) else $error("word moved");
	chk_harm_off: assert property (ref_lock_mode[*3] |-> !harmonic_seen)
		else $error("harmonic in ref mode");
	chk_harm_lol: assert property ((harmonic_seen && !lol_output_select)
		|-> ##[0:3] lock_lost_out) else $error("harmonic lol");
endmodule // cld_lock_detect_control_checker

bind cld_lock_detect_control cld_lock_detect_control_checker #(.TW(TW), .LW(LW))
	chk_u (.ref_clk(ref_clk), .resetn(resetn), .signal_level(signal_level),
	.los_threshold(los_threshold), .ref_lock_mode(ref_lock_mode),
	.los_polarity(los_polarity), .sticky_clear(sticky_clear),
	.lol_output_select(lol_output_select), .vco_tune_word(vco_tune_word),
	.freq_loop_enable(freq_loop_enable), .lock_lost_out(lock_lost_out),
	.signal_absent_out(signal_absent_out), .lock_status(lock_status),
	.harmonic_seen(harmonic_seen));

// ==== cld_frontend_model.sv ====
// Behavioural front end: serial data, reference clock and oscillator pins.
// Assumes the bench sets both half periods; the oscillator follows the word.
module cld_frontend_model #(
	parameter int TW      = 12,
	parameter int LSB_HZ  = 2000,
	parameter int STEP_HZ = 10000
) (
	input  wire [TW-1:0] vco_tune_word,
	input  int           data_half_ns,
	input  int           ref_half_ns,
	output logic         vco_clock_in,
	output logic         data_in,
	output logic         aux_ref_clock_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;

	// Rates are whole edges per window so a matching word counts the same
	// every window; a finer model would make the lock chatter. Word zero
	// stops the oscillator, and the offset keeps edges off the clock edges.
	initial begin
		vco_clock_in = 1'b0;
		#0.3;
		forever begin
			n = vco_tune_word * LSB_HZ / STEP_HZ;
			if (n == 0)
				#100;
			else begin
				#(5.0e8 / (n * STEP_HZ));
				vco_clock_in = ~vco_clock_in;
			end
		end
	end

	// Data carries an alternating pattern; the reference runs free.
	initial begin
		data_in = 1'b0;
		forever begin
			#(data_half_ns);
			data_in = ~data_in;
		end
	end
	initial begin
		aux_ref_clock_in = 1'b0;
		forever begin
			#(ref_half_ns);
			aux_ref_clock_in = ~aux_ref_clock_in;
		end
	end
endmodule // cld_frontend_model

// ==== cld_lock_detect_control_tb.sv ====
// Self-checking bench for the lock detect and acquisition control block.
// Assumes the front end model drives data, reference and oscillator pins.
module cld_lock_detect_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Model scale chosen so the coarse step lands on both targets: each
	// lock then takes a few windows rather than a long halving walk.
	localparam int LSB_HZ = 489;
	// Words that give one and the same edge count span about 21 codes.
	localparam int BAND   = 21;
	localparam int WIN    = 4000;
	logic        ref_clk, resetn, vco_clock_in, data_in, aux_ref_clock_in;
	logic        ref_lock_mode, fine_readback_enable, los_polarity;
	logic        sticky_clear, lol_output_select, freq_loop_enable;
	logic        lock_lost_out, signal_absent_out, harmonic_seen;
	logic [7:0]  signal_level, los_threshold, lock_status;
	logic [1:0]  ref_range;
	logic [3:0]  rate_ratio;
	logic [11:0] vco_tune_word;
	int          data_half_ns = 1000;
	int          ref_half_ns  = 500;
	int          error_cnt    = 0;
	int          checks       = 0;

	cld_lock_detect_control dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.vco_clock_in(vco_clock_in), .data_in(data_in),
		.aux_ref_clock_in(aux_ref_clock_in), .signal_level(signal_level),
		.los_threshold(los_threshold), .ref_lock_mode(ref_lock_mode),
		.fine_readback_enable(fine_readback_enable), .ref_range(ref_range),
		.rate_ratio(rate_ratio), .los_polarity(los_polarity),
		.sticky_clear(sticky_clear), .lol_output_select(lol_output_select),
		.vco_tune_word(vco_tune_word), .freq_loop_enable(freq_loop_enable),
		.lock_lost_out(lock_lost_out), .signal_absent_out(signal_absent_out),
		.lock_status(lock_status), .harmonic_seen(harmonic_seen));
	cld_frontend_model #(.LSB_HZ(LSB_HZ)) fe_u (.vco_tune_word(vco_tune_word),
		.data_half_ns(data_half_ns), .ref_half_ns(ref_half_ns),
		.vco_clock_in(vco_clock_in), .data_in(data_in),
		.aux_ref_clock_in(aux_ref_clock_in));

	// The 40 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// A matching word may sit anywhere in one count step above the ideal.
	task automatic band(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		checks++;
		if ((got >= exp && got < exp + BAND) !== 1'b1) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_lol(input logic v, input int max);
		int n;
		n = 0;
		while (lock_lost_out !== v && n < max) begin
			@(negedge ref_clk);
			n++;
		end
		check("lock_lost_out", {11'h0, v}, {11'h0, lock_lost_out});
	endtask

	task automatic lock_check(input string what, input logic [11:0] exp);
		wait_lol(1'b0, 8 * WIN);
		@(negedge ref_clk);
		check("freq_loop_enable", 12'h0, {11'h0, freq_loop_enable});
		band(what, exp, vco_tune_word);
	endtask

	// Set, hold and release points of signal-absent under both polarities.
	task automatic los_test();
		logic [7:0] lv [4] = '{8'h1e, 8'h0a, 8'h27, 8'h28};
		logic       on [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++) begin
				@(posedge ref_clk);
				los_polarity <= p[0];
				signal_level <= lv[i];
				repeat (3) @(negedge ref_clk);
				check("signal_absent_out", {11'h0, on[i] ^ p[0]},
					{11'h0, signal_absent_out});
			end
		end
	endtask

	// Lock to a scaled reference, then step every range code with a
	// matching ratio so that the target does not move.
	task automatic ref_test();
		@(posedge ref_clk);
		rate_ratio <= 4'h2;
		ref_range <= 2'h2;
		ref_lock_mode <= 1'b1;
		lock_check("ref word", 12'(500000000 / ref_half_ns / LSB_HZ));
		check("lock_status", 12'h0, {4'h0, lock_status});
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			ref_range <= 2'(k);
			rate_ratio <= 4'(k);
			repeat (WIN + 100) @(negedge ref_clk);
			check("lock_lost_out", 12'h0, {11'h0, lock_lost_out});
			check("harmonic_seen", 12'h0, {11'h0, harmonic_seen});
		end
	endtask

	// Leaving reference mode moves the target, so lock is lost and regained.
	task automatic loss_test();
		@(posedge ref_clk);
		ref_lock_mode <= 1'b0;
		wait_lol(1'b1, 2 * WIN + 100);
		repeat (4) @(negedge ref_clk);
		check("vco_tune_word", 12'h0, vco_tune_word);
		check("lock_status", 12'h10, {4'h0, lock_status});
		lock_check("data word", 12'(500000000 / data_half_ns / LSB_HZ));
		check("lock_status", 12'h10, {4'h0, lock_status});
	endtask

	// Mirror the sticky bit on the pin, then clear it with one then zero.
	task automatic clear_test();
		@(posedge ref_clk);
		lol_output_select <= 1'b1;
		@(negedge ref_clk);
		check("lock_lost_out", 12'h1, {11'h0, lock_lost_out});
		@(posedge ref_clk);
		sticky_clear <= 1'b1;
		repeat (3) @(negedge ref_clk);
		check("lock_status", 12'h10, {4'h0, lock_status});
		@(posedge ref_clk);
		sticky_clear <= 1'b0;
		repeat (4) @(negedge ref_clk);
		check("lock_status", 12'h0, {4'h0, lock_status});
		check("lock_lost_out", 12'h0, {11'h0, lock_lost_out});
	endtask

	task automatic final_report();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence; fine readback stays off throughout.
	initial begin
		resetn = 1'b0;
		signal_level = 8'h1e;
		los_threshold = 8'h14;
		ref_lock_mode = 1'b0;
		fine_readback_enable = 1'b0;
		ref_range = 2'h0;
		rate_ratio = 4'h0;
		los_polarity = 1'b0;
		sticky_clear = 1'b0;
		lol_output_select = 1'b0;
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		los_test();
		ref_test();
		loss_test();
		clear_test();
		final_report();
	end

	// Two short acquisitions, the range steps and a loss take about
	// twenty-two windows at worst; twenty-four leaves a margin.
	initial begin
		repeat (24 * WIN) @(posedge ref_clk);
		error_cnt++;
		$display("ERROR watchdog expected finish seen timeout");
		final_report();
	end
endmodule // cld_lock_detect_control_tb
